// ### isp_ctrl.v
// input, sync monitor and power control register bank
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "isp_defs.vh"
module isp_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // register port
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata_q,
  // pins and front-end status
  input  wire        pwrdn_pin,
  input  wire        line_sync_ch_a,
  input  wire        line_sync_ch_b,
  input  wire        green_embedded_sync_ch_a,
  input  wire        green_embedded_sync_ch_b,
  input  wire [3:0]  sync_detect,
  input  wire        clamp_end,
  input  wire        vsync_in,
  input  wire        coast,
  // analog front-end controls
  output reg         offset_update_q,
  output reg         auto_offset_q,
  output reg  [4:0]  slicer_thr_q,
  output reg         high_bw_q,
  output reg         chan_b_sel_q,
  output reg         chip_pd_q,
  output reg         data_oe_q,
  // sync monitor pin
  output reg         sync_monitor_output,
  output reg         sync_monitor_oe_q
);
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_PD   = 3'b010;
  localparam [2:0] ST_FAST = 3'b100;

  reg  [7:0] offset_ctl_q;
  reg  [7:0] test0_q;
  reg  [7:0] slicer_q;
  reg  [7:0] inpwr_q;
  reg  [2:0] st_q;
  reg  [2:0] st_d;
  reg  [1:0] pin_s_q;
  reg  [1:0] lsa_s_q;
  reg  [1:0] lsb_s_q;
  reg  [1:0] gsa_s_q;
  reg  [1:0] gsb_s_q;
  reg  [1:0] vs_s_q;
  reg  [1:0] co_s_q;
  reg  [7:0] det_s1_q;
  reg  [3:0] det_s2_q;
  reg        auto_ch_q;
  reg        line_prev_q;
  reg        vs_prev_q;
  reg        mon_src;
  wire       chan_b;
  wire       line_sel;
  wire       green_sel;
  wire       pin_active;
  wire       pd_req;
  wire       sync_rise;
  wire       regen;
  wire       filt;
  wire       upd;

  // selects a named bit of a register value
  function fld;
    input [7:0] v;
    input integer b;
    begin
      fld = v[b];
    end
  endfunction

  // register write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_ctl_q <= `ISP_RST_OFFSET_CTL;
      test0_q      <= `ISP_RST_TEST0;
      slicer_q     <= `ISP_RST_SLICER;
      inpwr_q      <= `ISP_RST_INPWR;
    end else if (wr) begin
      case (addr)
        `ISP_OFS_OFFSET_CTL: offset_ctl_q <= wdata;
        `ISP_OFS_TEST0:      test0_q      <= wdata;
        `ISP_OFS_SLICER:     slicer_q     <= wdata;
        `ISP_OFS_INPWR:      inpwr_q      <= wdata;
        default: ;
      endcase
    end
  end

  // register read, data one cycle after strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ISP_OFS_OFFSET_CTL: rdata_q <= offset_ctl_q;
        `ISP_OFS_TEST0:      rdata_q <= test0_q;
        `ISP_OFS_SLICER:     rdata_q <= slicer_q;
        `ISP_OFS_INPWR:      rdata_q <= inpwr_q;
        `ISP_OFS_STATUS:     rdata_q <= {st_q, chan_b, det_s2_q};
        default:             rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // power-down pin synchroniser, kept apart: only the power path reads it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s_q <= 2'h0;
    end else begin
      pin_s_q <= {pin_s_q[0], pwrdn_pin};
    end
  end

  // two-stage synchronisers for the raw syncs, vertical sync and coast
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lsa_s_q <= 2'h0;
      lsb_s_q <= 2'h0;
      gsa_s_q <= 2'h0;
      gsb_s_q <= 2'h0;
      vs_s_q  <= 2'h0;
      co_s_q  <= 2'h0;
    end else begin
      lsa_s_q <= {lsa_s_q[0], line_sync_ch_a};
      lsb_s_q <= {lsb_s_q[0], line_sync_ch_b};
      gsa_s_q <= {gsa_s_q[0], green_embedded_sync_ch_a};
      gsb_s_q <= {gsb_s_q[0], green_embedded_sync_ch_b};
      vs_s_q  <= {vs_s_q[0], vsync_in};
      co_s_q  <= {co_s_q[0], coast};
    end
  end

  // detect flags: a slow status word, one extra stage costs nothing
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      det_s1_q <= 8'h00;
      det_s2_q <= 4'h0;
    end else begin
      det_s1_q <= {det_s1_q[3:0], sync_detect};
      det_s2_q <= det_s1_q[7:4];
    end
  end

  // automatic pick: channel a while it shows sync, else b if b does
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_ch_q <= 1'b0;
    end else if (det_s2_q[1:0] != 2'h0) begin
      auto_ch_q <= 1'b0;
    end else if (det_s2_q[3:2] != 2'h0) begin
      auto_ch_q <= 1'b1;
    end
  end

  // select bit held but unused while override is clear
  assign chan_b = fld(inpwr_q, `ISP_B_CH_OVR) ?
                  fld(inpwr_q, `ISP_B_CH_SEL) : auto_ch_q;
  assign line_sel  = chan_b ? lsb_s_q[1] : lsa_s_q[1];
  assign green_sel = chan_b ? gsb_s_q[1] : gsa_s_q[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_prev_q <= 1'b0;
      vs_prev_q   <= 1'b0;
    end else begin
      line_prev_q <= line_sel;
      vs_prev_q   <= vs_s_q[1];
    end
  end
  assign sync_rise = line_sel && !line_prev_q;

  isp_sync_clean u_clean (
    .clk       (clk),
    .rst_n     (rst_n),
    .sync_rise (sync_rise),
    .coast     (co_s_q[1]),
    .regen_q   (regen),
    .filt_q    (filt)
  );

  isp_offset_timer u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (fld(offset_ctl_q, `ISP_B_AUTO_OFS)),
    .rate       (offset_ctl_q[`ISP_B_UPD_HI:`ISP_B_UPD_LO]),
    .clamp_end  (clamp_end),
    .vsync_rise (vs_s_q[1] && !vs_prev_q),
    .update_q   (upd)
  );

  // power-down decision
  assign pin_active = fld(inpwr_q, `ISP_B_PD_POL) ?
                      pin_s_q[1] : !pin_s_q[1];
  // pin and bit ignored under automatic control, yet kept
  assign pd_req = fld(inpwr_q, `ISP_B_PD_AUTO) ?
                  (det_s2_q == 4'h0) :
                  (fld(inpwr_q, `ISP_B_PD) || pin_active);

  always @* begin
    case (st_q)
      ST_RUN, ST_PD, ST_FAST: begin
        if (!pd_req)
          st_d = ST_RUN;
        else if (fld(inpwr_q, `ISP_B_FAST_SW))
          st_d = ST_FAST;
        else
          st_d = ST_PD;
      end
      default: st_d = ST_RUN;
    endcase
  end

  // monitor source mux
  always @* begin
    case (slicer_q[`ISP_B_MON_SEL_HI:`ISP_B_MON_SEL_LO])
      `ISP_MON_RAW_SLICE: mon_src = green_sel;
      `ISP_MON_RAW_LINE:  mon_src = line_sel;
      `ISP_MON_REGEN:     mon_src = regen;
      `ISP_MON_FILTERED:  mon_src = filt;
      default:            mon_src = line_sel;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // front-end controls, one cycle behind the registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_update_q <= 1'b0;
      auto_offset_q   <= 1'b0;
      slicer_thr_q    <= 5'h0F;
      high_bw_q       <= 1'b1;
      chan_b_sel_q    <= 1'b0;
    end else begin
      // no refresh while the converters are unpowered
      offset_update_q <= upd && (st_q != ST_PD);
      auto_offset_q   <= fld(offset_ctl_q, `ISP_B_AUTO_OFS);
      // code n means (n+1)*8 mV at the comparator
      slicer_thr_q    <= slicer_q[`ISP_B_THR_HI:`ISP_B_THR_LO];
      high_bw_q       <= fld(inpwr_q, `ISP_B_BW);
      chan_b_sel_q    <= chan_b;
    end
  end

  // power outputs follow the next state, saving a cycle of latency
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_pd_q <= 1'b0;
      data_oe_q <= 1'b1;
    end else begin
      chip_pd_q <= (st_d == ST_PD);
      data_oe_q <= (st_d == ST_RUN);
    end
  end

  // sync monitor pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_monitor_output <= 1'b1;
      sync_monitor_oe_q   <= 1'b1;
    end else begin
      // source is active high internally; invert for low polarity
      sync_monitor_output <= fld(slicer_q, `ISP_B_MON_POL) ?
                             mon_src : !mon_src;
      sync_monitor_oe_q   <= !((st_d != ST_RUN) &&
                             fld(inpwr_q, `ISP_B_MON_HIZ));
    end
  end
endmodule
`default_nettype wire

// ### isp_ctrl_bench.sv
// self-checking bench for the control register bank
`timescale 1ns/10ps
`default_nettype none
`include "isp_defs.vh"
module isp_ctrl_bench;
  logic        clk, rst_n, wr, rd, pwrdn_pin, en_a, en_b;
  logic [7:0]  addr, wdata, rdata_q;
  logic        line_sync_ch_a, line_sync_ch_b, clamp_end, vsync_in, coast;
  logic        green_embedded_sync_ch_a, green_embedded_sync_ch_b;
  logic [3:0]  sync_detect;
  logic [4:0]  slicer_thr_q;
  logic        offset_update_q, auto_offset_q, high_bw_q, chan_b_sel_q;
  logic        chip_pd_q, data_oe_q, sync_monitor_output, sync_monitor_oe_q;
  logic [11:0] c;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;
  logic [7:0]  rst_v [4] = '{`ISP_RST_OFFSET_CTL, `ISP_RST_TEST0,
                             `ISP_RST_SLICER, `ISP_RST_INPWR};
  logic [7:0]  rate_n [4] = '{8'd1, 8'd16, 8'd64, 8'd4};
  logic [7:0]  ch_reg [4] = '{8'h24, 8'hA4, 8'hE4, 8'h64};
  // {pin, register, power-down, data enable, monitor enable}
  logic [11:0] pwr_case [7] = '{12'h023, 12'h925, 12'h903, 12'h105,
                                12'h94C, 12'h958, 12'h983};
  isp_ctrl u_isp_ctrl (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata_q,
    .pwrdn_pin, .line_sync_ch_a, .line_sync_ch_b, .green_embedded_sync_ch_a,
    .green_embedded_sync_ch_b, .sync_detect, .clamp_end, .vsync_in, .coast,
    .offset_update_q, .auto_offset_q, .slicer_thr_q, .high_bw_q,
    .chan_b_sel_q, .chip_pd_q, .data_oe_q, .sync_monitor_output,
    .sync_monitor_oe_q);
  isp_src_model u_isp_src_model (.clk, .rst_n, .en_a, .en_b, .line_sync_ch_a,
    .line_sync_ch_b, .green_embedded_sync_ch_a, .green_embedded_sync_ch_b,
    .sync_detect, .clamp_end, .vsync_in, .coast);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: the slowest refresh interval dominates the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata_q, exp);
  endtask
  initial begin
    rst_n     = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
    pwrdn_pin = 1'b1;
    en_a      = 1'b1;
    en_b      = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd_chk(`ISP_OFS_OFFSET_CTL + i[7:0], rst_v[i]);
    rd_chk(8'h30, 8'h00);
    chk(slicer_thr_q, 8'h0F);
    chk(high_bw_q, 8'h01);
    $display("test reset done");
    wr_reg(`ISP_OFS_TEST0, 8'hFF);
    rd_chk(`ISP_OFS_TEST0, 8'hFF);
    for (int t = 0; t < 32; t += 31) begin
      wr_reg(`ISP_OFS_SLICER, {t[4:0], 3'h0});
      tick(3);
      chk(slicer_thr_q, t[7:0]);
      rd_chk(`ISP_OFS_SLICER, {t[4:0], 3'h0});
    end
    $display("test threshold done");
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 2; p++) begin
        wr_reg(`ISP_OFS_SLICER, {5'h0F, p[0], s[1:0]});
        // a line outside coast, so the filtered pulse is not suppressed
        do @(posedge line_sync_ch_a); while (coast);
        n = 0;
        repeat (14) begin
          @(posedge clk);
          #1 n += (sync_monitor_output === p[0]);
        end
        chk(n[7:0], (s < 2) ? 8'h08 : 8'h01);
        tick(30);
        chk(sync_monitor_output, !p[0]);
      end
    $display("test monitor done");
    for (int r = 0; r < 4; r++) begin
      wr_reg(`ISP_OFS_OFFSET_CTL, {3'h3, r[1:0], 3'h3});
      repeat (2) @(posedge offset_update_q);
      n = 0;
      do begin
        @(posedge clk);
        #1 n += clamp_end;
      end while (!offset_update_q);
      chk(n[7:0], rate_n[r]);
    end
    wr_reg(`ISP_OFS_OFFSET_CTL, 8'h5B);
    tick(800);
    chk(auto_offset_q, 8'h00);
    rd_chk(`ISP_OFS_OFFSET_CTL, 8'h5B);
    $display("test offset done");
    @(posedge clk);
    pwrdn_pin <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      en_a <= i > 1;
      wr_reg(`ISP_OFS_INPWR, ch_reg[i]);
      tick(8);
      chk(chan_b_sel_q, !i[0]);
      rd_chk(`ISP_OFS_INPWR, ch_reg[i]);
    end
    $display("test channel done");
    for (int i = 0; i < 7; i++) begin
      c = pwr_case[i];
      @(posedge clk);
      pwrdn_pin <= c[11];
      wr_reg(`ISP_OFS_INPWR, c[10:3]);
      tick(8);
      chk(chip_pd_q, c[2]);
      if (!c[2]) chk(data_oe_q, c[1]);
      chk(sync_monitor_oe_q, c[0]);
      chk(high_bw_q, c[8]);
      rd_chk(`ISP_OFS_INPWR, c[10:3]);
    end
    @(posedge clk);
    en_a <= 1'b0;
    en_b <= 1'b0;
    tick(10);
    chk(chip_pd_q, 8'h01);
    $display("test power done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ### isp_ctrl_props.sv
// assertions on the control register bank ports
`timescale 1ns/10ps
`default_nettype none
`include "isp_defs.vh"
module isp_ctrl_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata_q,
  // front end and pins
  input wire logic [3:0] sync_detect,
  input wire logic       offset_update_q,
  input wire logic       auto_offset_q,
  input wire logic [4:0] slicer_thr_q,
  input wire logic       high_bw_q,
  input wire logic       chan_b_sel_q,
  input wire logic       chip_pd_q,
  input wire logic       sync_monitor_oe_q
);
  logic [7:0] pwr_q;
  // shadow of the power register, rebuilt from the write strobe
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) pwr_q <= `ISP_RST_INPWR;
    else if (wr && addr == `ISP_OFS_INPWR) pwr_q <= wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_idle: assert property (!$past(rd) |-> rdata_q == 8'h00)
    else $error("read data not zero outside read slot");
  a_thr_follows: assert property ((wr && addr == `ISP_OFS_SLICER) |->
    ##2 slicer_thr_q == $past(wdata[7:3], 2)) else $error("threshold lost");
  a_bw_follows: assert property ((wr && addr == `ISP_OFS_INPWR) |->
    ##2 high_bw_q == $past(wdata[5], 2)) else $error("bandwidth lost");
  a_manual_pd: assert property ((pwr_q[4:3] == 2'h1 && !pwr_q[1])[*3] |->
    chip_pd_q) else $error("register power-down ignored");
  a_fast_run: assert property (pwr_q[1] [*3] |-> !chip_pd_q)
    else $error("fast switch powered down");
  a_mon_hiz: assert property ((chip_pd_q && pwr_q[0])[*3] |->
    !sync_monitor_oe_q) else $error("monitor driven in power-down");
  a_mon_kept: assert property (!pwr_q[0] [*3] |-> sync_monitor_oe_q)
    else $error("monitor released");
  a_offset_off: assert property (!auto_offset_q [*3] |-> !offset_update_q)
    else $error("refresh without auto offset");
  a_chan_user: assert property ((pwr_q[7] && $stable(pwr_q[6]))[*4] |->
    chan_b_sel_q == pwr_q[6]) else $error("user channel ignored");
  a_auto_pd: assert property ((pwr_q[4] && !pwr_q[1] && sync_detect == 4'h0)[*6]
    |-> chip_pd_q) else $error("no power-down without sync");
  a_auto_run: assert property ((pwr_q[4] && sync_detect != 4'h0)[*6]
    |-> !chip_pd_q) else $error("power-down with sync present");
  c_refresh: cover property (offset_update_q);
  c_pd: cover property ($rose(chip_pd_q));
  c_mon_off: cover property ($fell(sync_monitor_oe_q));
endmodule
bind isp_ctrl isp_ctrl_props u_isp_ctrl_props (.clk, .rst_n, .addr, .wdata,
  .wr, .rd, .rdata_q, .sync_detect, .offset_update_q, .auto_offset_q,
  .slicer_thr_q, .high_bw_q, .chan_b_sel_q, .chip_pd_q, .sync_monitor_oe_q);
`default_nettype wire

// ### isp_defs.vh
// register offsets, field positions, reset values and timing counts
`ifndef ISP_DEFS_VH
`define ISP_DEFS_VH
`define ISP_ADDR_W         8
`define ISP_OFS_OFFSET_CTL 8'h1B
`define ISP_OFS_TEST0      8'h1C
`define ISP_OFS_SLICER     8'h1D
`define ISP_OFS_INPWR      8'h1E
`define ISP_OFS_STATUS     8'h40
`define ISP_RST_OFFSET_CTL 8'h58
`define ISP_RST_TEST0      8'h00
`define ISP_RST_SLICER     8'h78
`define ISP_RST_INPWR      8'h20
`define ISP_B_AUTO_OFS     5
`define ISP_B_UPD_HI       4
`define ISP_B_UPD_LO       3
`define ISP_B_THR_HI       7
`define ISP_B_THR_LO       3
`define ISP_B_MON_POL      2
`define ISP_B_MON_SEL_HI   1
`define ISP_B_MON_SEL_LO   0
`define ISP_B_CH_OVR       7
`define ISP_B_CH_SEL       6
`define ISP_B_BW           5
`define ISP_B_PD_AUTO      4
`define ISP_B_PD           3
`define ISP_B_PD_POL       2
`define ISP_B_FAST_SW      1
`define ISP_B_MON_HIZ      0
`define ISP_UPD_EVERY_1    2'h0
`define ISP_UPD_EVERY_16   2'h1
`define ISP_UPD_EVERY_64   2'h2
`define ISP_UPD_VSYNC      2'h3
`define ISP_CNT_16         6'h0F
`define ISP_CNT_64         6'h3F
`define ISP_MON_RAW_SLICE  2'h0
`define ISP_MON_RAW_LINE   2'h1
`define ISP_MON_REGEN      2'h2
`define ISP_MON_FILTERED   2'h3
`define ISP_WIN_LO         12'h040
`define ISP_WIN_HI         12'hFC0
`define ISP_LINE_NOM       12'h200
`endif

// ### isp_offset_timer.v
// offset refresh pacing from clamp periods or vertical periods
`timescale 1ns/10ps
`default_nettype none
`include "isp_defs.vh"
module isp_offset_timer (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // control
  input  wire        enable,
  input  wire [1:0]  rate,
  // timing events
  input  wire        clamp_end,
  input  wire        vsync_rise,
  // refresh strobe
  output reg         update_q
);
  reg  [5:0] cnt_q;
  wire [5:0] limit;

  assign limit = (rate == `ISP_UPD_EVERY_16) ? `ISP_CNT_16 :
                 (rate == `ISP_UPD_EVERY_64) ? `ISP_CNT_64 : 6'h00;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 6'h00;
      update_q <= 1'b0;
    end else if (!enable) begin
      // manual offset in force: no refreshes
      cnt_q    <= 6'h00;
      update_q <= 1'b0;
    end else if (rate == `ISP_UPD_VSYNC) begin
      cnt_q    <= 6'h00;
      update_q <= vsync_rise;
    end else if (clamp_end) begin
      if (cnt_q >= limit) begin
        cnt_q    <= 6'h00;
        update_q <= 1'b1;
      end else begin
        cnt_q    <= cnt_q + 6'h01;
        update_q <= 1'b0;
      end
    end else begin
      update_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### isp_src_model.sv
// video source model: line and green syncs, clamp end, vertical sync
`timescale 1ns/10ps
`default_nettype none
module isp_src_model #(
  parameter int LINE  = 128,
  parameter int FRAME = 4
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // channels carrying sync
  input  wire logic       en_a,
  input  wire logic       en_b,
  // syncs and timing
  output wire logic       line_sync_ch_a,
  output wire logic       line_sync_ch_b,
  output wire logic       green_embedded_sync_ch_a,
  output wire logic       green_embedded_sync_ch_b,
  output wire logic [3:0] sync_detect,
  output wire logic       clamp_end,
  output wire logic       vsync_in,
  output wire logic       coast
);
  int pos_q;
  int ln_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 0;
      ln_q  <= 0;
    end else begin
      pos_q <= (pos_q == LINE - 1) ? 0 : pos_q + 1;
      if (pos_q == LINE - 1)
        ln_q <= (ln_q == FRAME - 1) ? 0 : ln_q + 1;
    end
  end
  // line period kept inside the filter window
  assign line_sync_ch_a           = en_a && pos_q < 8;
  assign line_sync_ch_b           = en_b && pos_q < 8;
  assign green_embedded_sync_ch_a = line_sync_ch_a;
  assign green_embedded_sync_ch_b = line_sync_ch_b;
  assign sync_detect              = {en_b, en_b, en_a, en_a};
  assign clamp_end                = pos_q == 16;
  assign vsync_in                 = ln_q == 0;
  assign coast                    = vsync_in;
endmodule
`default_nettype wire

// ### isp_sync_clean.v
// sync filter: passes pulses inside the window, regenerates missing ones
`timescale 1ns/10ps
`default_nettype none
`include "isp_defs.vh"
module isp_sync_clean (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // sync in
  input  wire        sync_rise,
  input  wire        coast,
  // outputs
  output reg         regen_q,
  output reg         filt_q
);
  reg  [11:0] cnt_q;
  reg  [11:0] per_q;
  wire        in_win;
  wire        missing;

  assign in_win  = (cnt_q >= `ISP_WIN_LO) && (cnt_q <= `ISP_WIN_HI);
  // period overrun or coasting: insert a pulse at the learned period
  assign missing = (cnt_q == per_q) && !(sync_rise && in_win);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= 12'h000;
      per_q   <= `ISP_LINE_NOM;
      regen_q <= 1'b0;
      filt_q  <= 1'b0;
    end else begin
      filt_q  <= sync_rise && in_win && !coast;
      regen_q <= (sync_rise && in_win && !coast) || missing
                 || (coast && cnt_q == per_q);
      if ((sync_rise && in_win && !coast) || missing ||
          (coast && cnt_q == per_q)) begin
        if (sync_rise && in_win && !coast)
          per_q <= cnt_q;
        cnt_q <= 12'h000;
      end else if (cnt_q != 12'hFFF) begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire
